// >>> byte_multiply_divide_unit.sv
// byte multiply/divide datapath of a small 8-bit core
// assumes: sequencer pulses op_start for one cycle with operands stable
// and waits for op_done before the next request
// and that results reach the core registers only through the *_we strobes
`timescale 1ns/100ps

module byte_multiply_divide_unit
    import mul_div_pkg::*;
(
    input  wire logic                  clk_sys,     // core clock, 100 MHz
    input  wire logic                  rst_n,       // async reset, active low
    input  wire logic                  op_start,    // one-cycle request pulse
    input  mul_div_pkg::op_t           op_sel,      // operation selector
    input  wire logic [7:0]            acc_in,      // accumulator value
    input  wire logic [7:0]            ptr_lo_in,   // lower pointer value
    input  wire logic [7:0]            ptr_hi_in,   // upper pointer value
    output logic                       busy,        // operation in flight
    output logic                       op_done,     // one-cycle completion pulse
    output logic      [7:0]            acc_out,     // new accumulator
    output logic      [7:0]            ptr_lo_out,  // new lower pointer
    output logic      [7:0]            ptr_hi_out,  // new upper pointer
    output logic                       acc_we,      // write accumulator, with op_done
    output logic                       ptr_lo_we,   // write lower pointer
    output logic                       ptr_hi_we,   // write upper pointer
    output logic                       carry_we,    // write carry flag
    output logic                       carry_out    // new carry flag value
);
    import mul_div_pkg::*;

    // =========================================================
    // sequencing state
    // =========================================================
    // a small counter-driven sequencer: idle takes one request, the busy
    // state counts down a fixed latency and the last count writes results
    // back; nothing is pipelined, so only one operation is ever in flight
    typedef enum logic [1:0] {
        ST_IDLE,   // waiting for a request
        ST_MUL,    // multiply in flight
        ST_DIV     // divide in flight
    } state_t;

    // sequencer state and captured operands
    state_t     state_q, state_d;       // current activity
    logic [2:0] cnt_q, cnt_d;           // cycles left in the operation
    logic [15:0] prod_q, prod_d;        // captured product
    logic [15:0] dvd_q, dvd_d;          // captured dividend
    logic [7:0]  dvs_q, dvs_d;          // captured divisor
    logic        div_load;              // one-cycle load of divider stage

    // divider results, held by the stage register until its next load
    logic [7:0] quot;   // quotient low byte
    logic [7:0] rem;    // remainder low byte
    logic       ovf;    // overflow or zero divisor

    // output registers; every port comes straight from one of these so the
    // sequencer sees no combinational path from its own operand buses
    logic       busy_d, done_d;                                // busy level, done pulse
    logic [7:0] acc_d, plo_d, phi_d;                           // result bytes
    logic       acc_we_d, plo_we_d, phi_we_d, cwe_d, cout_d;   // strobes and carry

    // counter start values: the count is loaded at the accepting edge and
    // results are registered when it reaches one, which puts op_done the
    // required number of cycles after acceptance; the 3-bit counter limits
    // either latency to at most 8 cycles
    localparam logic [2:0] MUL_LAST = 3'(PRODUCT_CYCLES - 1);  // multiply start count
    localparam logic [2:0] DIV_LAST = 3'(DIVIDE_CYCLES - 1);   // divide start count

    // =========================================================
    // divider stage
    // =========================================================
    // the divider computes in one cycle; the fixed latency is kept so
    // software timing matches the core, at the cost of idle cycles
    // its inputs are the captured operands, not the live request buses
    div_step u_div (
        .clk_sys  (clk_sys),
        .rst_n    (rst_n),
        .load     (div_load),
        .dividend (dvd_q),
        .divisor  (dvs_q),
        .quot_q   (quot),
        .rem_q    (rem),
        .ovf_q    (ovf)
    );

    // =========================================================
    // next-state and result logic
    // =========================================================
    // defaults hold every register and clear the strobes, so each pulse
    // lasts exactly one cycle unless a branch raises it again
    always_comb begin
        state_d  = state_q;
        cnt_d    = cnt_q;
        prod_d   = prod_q;
        dvd_d    = dvd_q;
        dvs_d    = dvs_q;
        div_load = 1'b0;
        busy_d   = busy;
        done_d   = 1'b0;
        acc_d    = acc_out;
        plo_d    = ptr_lo_out;
        phi_d    = ptr_hi_out;
        acc_we_d = 1'b0;
        plo_we_d = 1'b0;
        phi_we_d = 1'b0;
        cwe_d    = 1'b0;
        cout_d   = carry_out;
        case (state_q)
            ST_IDLE: begin
                // requests while busy are ignored; only idle accepts
                // a request in the completion cycle is taken, the state being idle
                if (op_start && op_sel == OP_PRODUCT) begin
                    // zero-extended operands keep the product unsigned
                    prod_d  = {8'h00, ptr_lo_in} * {8'h00, acc_in};
                    cnt_d   = MUL_LAST;
                    state_d = ST_MUL;
                    busy_d  = 1'b1;
                end else if (op_start && op_sel == OP_DIVIDE) begin
                    // dividend is upper pointer : accumulator, divisor lower pointer
                    dvd_d   = {ptr_hi_in, acc_in};
                    dvs_d   = ptr_lo_in;
                    cnt_d   = DIV_LAST;
                    state_d = ST_DIV;
                    busy_d  = 1'b1;
                end
                // OP_NONE, or no request, leaves every register as it is
            end
            ST_MUL: begin
                // the product was formed at acceptance; the count only
                // stretches the answer to the fixed multiply latency
                if (cnt_q == 3'h1) begin
                    // final cycle: split the product onto two registers
                    plo_d    = prod_q[15:8];
                    acc_d    = prod_q[7:0];
                    plo_we_d = 1'b1;
                    acc_we_d = 1'b1;
                    done_d   = 1'b1;
                    busy_d   = 1'b0;
                    state_d  = ST_IDLE;
                end else begin
                    cnt_d = cnt_q - 3'h1;
                end
            end
            ST_DIV: begin
                // operands are captured, so the request buses may change freely
                // load the stage early so results are ready at the end
                if (cnt_q == DIV_LAST) begin
                    div_load = 1'b1;
                end
                if (cnt_q == 3'h1) begin
                    acc_d    = quot;
                    phi_d    = rem;
                    // carry follows the stage flag: set on overflow, cleared otherwise
                    cout_d   = ovf;
                    acc_we_d = 1'b1;
                    phi_we_d = 1'b1;
                    cwe_d    = 1'b1;
                    done_d   = 1'b1;
                    busy_d   = 1'b0;
                    state_d  = ST_IDLE;
                end else begin
                    cnt_d = cnt_q - 3'h1;
                end
            end
            default: begin
                // unreachable encoding: drop back to idle and release busy
                state_d = ST_IDLE;
                busy_d  = 1'b0;
            end
        endcase
    end

    // =========================================================
    // registers
    // =========================================================
    // registers only; all next values come from the process above.
    // reset clears the result bytes too, so outputs read before the
    // first completion show zeros rather than stale data
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            // asynchronous clear to constants only
            state_q    <= ST_IDLE;
            cnt_q      <= 3'h0;
            prod_q     <= 16'h0000;
            dvd_q      <= 16'h0000;
            dvs_q      <= RST_BYTE;
            busy       <= 1'b0;
            op_done    <= 1'b0;
            acc_out    <= RST_BYTE;
            ptr_lo_out <= RST_BYTE;
            ptr_hi_out <= RST_BYTE;
            acc_we     <= 1'b0;
            ptr_lo_we  <= 1'b0;
            ptr_hi_we  <= 1'b0;
            carry_we   <= 1'b0;
            carry_out  <= 1'b0;
        end else begin
            // every register updates on every edge
            state_q    <= state_d;
            cnt_q      <= cnt_d;
            prod_q     <= prod_d;
            dvd_q      <= dvd_d;
            dvs_q      <= dvs_d;
            busy       <= busy_d;
            op_done    <= done_d;
            acc_out    <= acc_d;
            ptr_lo_out <= plo_d;
            ptr_hi_out <= phi_d;
            acc_we     <= acc_we_d;
            ptr_lo_we  <= plo_we_d;
            ptr_hi_we  <= phi_we_d;
            carry_we   <= cwe_d;
            carry_out  <= cout_d;
        end
    end

endmodule : byte_multiply_divide_unit

// >>> mul_div_pkg.sv
// package for the byte multiply/divide datapath
// assumes: used by the datapath top and its divider step module
package mul_div_pkg;

    // =========================================================
    // widths and operation codes
    // =========================================================
    localparam int BYTE_W = 8;  // register width
    localparam int WORD_W = 16; // product / dividend width

    // operation request from the sequencer
    typedef enum logic [1:0] {
        OP_NONE,
        OP_PRODUCT,  // unsigned 8x8 multiply
        OP_DIVIDE    // unsigned 16/8 divide
    } op_t;

    // =========================================================
    // timing counts, in core clock cycles
    // =========================================================
    localparam int PRODUCT_CYCLES = 5; // multiply latency
    localparam int DIVIDE_CYCLES  = 6; // divide latency

    // all-ones quotient limit
    localparam logic [7:0] QUOT_MAX = 8'hff;

    // reset values
    localparam logic [7:0] RST_BYTE = 8'h00;

endpackage : mul_div_pkg

// >>> div_step.sv
// one combinational-plus-registered restoring divide stage set
// assumes: single clock domain, asynchronous active-low reset
`timescale 1ns/100ps
module div_step
    import mul_div_pkg::*;
(
    input  wire logic        clk_sys,   // core clock
    input  wire logic        rst_n,     // async reset, active low
    input  wire logic        load,      // start a divide
    input  wire logic [15:0] dividend,  // 16-bit dividend
    input  wire logic [7:0]  divisor,   // 8-bit divisor
    output logic      [7:0]  quot_q,    // quotient, registered
    output logic      [7:0]  rem_q,     // remainder, registered
    output logic             ovf_q      // overflow or zero divisor
);
    import mul_div_pkg::*;

    // =========================================================
    // result registers
    // =========================================================
    logic [7:0] quot_d;
    logic [7:0] rem_d;
    logic       ovf_d;
    logic [15:0] q_full; // full quotient, used to judge overflow
    logic [15:0] r_full; // full remainder

    // compute results once on load; zero divisor short-cut
    always_comb begin
        quot_d = quot_q;
        rem_d  = rem_q;
        ovf_d  = ovf_q;
        q_full = 16'h0000;
        r_full = 16'h0000;
        if (load) begin
            if (divisor == RST_BYTE) begin
                // zero divisor: flag it, leave results as garbage-free ones
                ovf_d  = 1'b1;
                quot_d = QUOT_MAX;
                rem_d  = RST_BYTE;
            end else begin
                // both operands unsigned
                q_full = dividend / {8'h00, divisor};
                r_full = dividend % {8'h00, divisor};
                ovf_d  = (q_full > {8'h00, QUOT_MAX});
                quot_d = q_full[7:0];
                rem_d  = r_full[7:0];
            end
        end
    end

    // register only
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            quot_q <= RST_BYTE;
            rem_q  <= RST_BYTE;
            ovf_q  <= 1'b0;
        end else begin
            quot_q <= quot_d;
            rem_q  <= rem_d;
            ovf_q  <= ovf_d;
        end
    end

endmodule : div_step

// >>> mdu_monitor.sv
// checker for the multiply/divide datapath, bound to its top
// assumes: one clock domain, operands valid at the accepting edge
`timescale 1ns/100ps
module mdu_monitor
    import mul_div_pkg::*;
(
    input wire logic       clk_sys,    // clock
    input wire logic       rst_n,      // reset
    input wire logic       op_start,   // request
    input mul_div_pkg::op_t op_sel,    // operation
    input wire logic [7:0] acc_in,     // accumulator
    input wire logic [7:0] ptr_lo_in,  // lower pointer
    input wire logic [7:0] ptr_hi_in,  // upper pointer
    input wire logic       busy,       // in flight
    input wire logic       op_done,    // done pulse
    input wire logic [7:0] acc_out,    // new acc
    input wire logic [7:0] ptr_lo_out, // new lower
    input wire logic [7:0] ptr_hi_out, // new upper
    input wire logic       acc_we,     // acc write
    input wire logic       ptr_lo_we,  // lower write
    input wire logic       ptr_hi_we,  // upper write
    input wire logic       carry_we,   // carry write
    input wire logic       carry_out   // new carry
);
    // ==========================================================
    // accepted requests
    // ==========================================================
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    logic mul_go;  // multiply taken at this edge
    logic div_go;  // divide taken at this edge
    logic div_ok;  // quotient fits, which also rules out a zero divisor
    assign mul_go = op_start && !busy && (op_sel == OP_PRODUCT);
    assign div_go = op_start && !busy && (op_sel == OP_DIVIDE);
    assign div_ok = ptr_hi_in < ptr_lo_in;
    // ==========================================================
    // assertions
    // ==========================================================
    mul_product_a: assert property (
        mul_go |-> ##5 op_done && ({ptr_lo_out, acc_out} == $past(ptr_lo_in, 5) * $past(acc_in, 5)))
        else $error("multiply product wrong");
    mul_write_a: assert property (
        mul_go |-> ##5 ptr_lo_we && acc_we && !ptr_hi_we && !carry_we)
        else $error("multiply strobes wrong");
    mul_unsigned_a: assert property (
        mul_go && acc_in[7] && ptr_lo_in[7] |-> ##5 ptr_lo_out >= 8'h40)
        else $error("multiply not unsigned");
    div_latency_a: assert property (
        div_go |=> !op_done [*5] ##1 op_done && acc_we && ptr_hi_we && carry_we)
        else $error("divide completion wrong");
    div_result_a: assert property (
        div_go && div_ok |-> ##6 ({ptr_hi_out, acc_out} == {8'($past({ptr_hi_in, acc_in}, 6)
        % $past(ptr_lo_in, 6)), 8'($past({ptr_hi_in, acc_in}, 6) / $past(ptr_lo_in, 6))}))
        else $error("divide result wrong");
    div_ovf_a: assert property (
        div_go && !div_ok |-> ##6 carry_out)
        else $error("overflow carry missing");
    div_clear_a: assert property (
        div_go && div_ok |-> ##6 !carry_out)
        else $error("carry not cleared");
    busy_hold_a: assert property (
        mul_go || div_go |=> busy [*4])
        else $error("busy dropped early");
    cover property (mul_go && acc_in[7] && ptr_lo_in[7]);
    cover property (div_go && div_ok);
    cover property (div_go && !div_ok);
endmodule : mdu_monitor
bind byte_multiply_divide_unit mdu_monitor u_mon (.*);

// >>> core_regfile.sv
// register file model on the sequencer side of the datapath
// assumes: bench preloads it, datapath strobes write it back
`timescale 1ns/100ps
module core_regfile
(
    input  wire logic        clk_sys,   // clock
    input  wire logic        rst_n,     // reset
    input  wire logic        ld,        // bench preload
    input  wire logic [24:0] ld_val,    // {carry, hi, lo, acc}
    input  wire logic [24:0] new_val,   // datapath results, same order
    input  wire logic [3:0]  we,        // {carry, hi, lo, acc} strobes
    output logic      [24:0] regs_q     // current registers
);
    logic [24:0] regs_d;  // next registers
    // each strobe touches only its own field, so an unwanted write shows
    always_comb begin
        regs_d = regs_q;
        for (int i = 0; i < 3; i++) begin
            if (we[i]) regs_d[i*8 +: 8] = new_val[i*8 +: 8];
        end
        if (we[3]) regs_d[24] = new_val[24];
        if (ld) regs_d = ld_val;
    end
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) regs_q <= 25'h0;
        else regs_q <= regs_d;
    end
endmodule : core_regfile

// >>> tb_byte_multiply_divide_unit.sv
// testbench: corner and random multiplies and divides
// assumes: regfile model feeds operands and takes results back
`timescale 1ns/100ps
module tb_byte_multiply_divide_unit;
    import mul_div_pkg::*;
    logic        clk_sys, rst_n, op_start, ld, busy, op_done, carry_out;
    wire  [3:0]  we;                             // {carry, hi, lo, acc}
    op_t         op_sel;
    logic [7:0]  acc_out, ptr_lo_out, ptr_hi_out;
    logic [24:0] ld_val, regs_q;
    logic [31:0] seed;
    int          mismatches, checks;
    byte_multiply_divide_unit u_dut (.clk_sys(clk_sys), .rst_n(rst_n), .op_start(op_start),
        .op_sel(op_sel), .acc_in(regs_q[7:0]), .ptr_lo_in(regs_q[15:8]),
        .ptr_hi_in(regs_q[23:16]), .busy(busy), .op_done(op_done), .acc_out(acc_out),
        .ptr_lo_out(ptr_lo_out), .ptr_hi_out(ptr_hi_out), .acc_we(we[0]),
        .ptr_lo_we(we[1]), .ptr_hi_we(we[2]), .carry_we(we[3]), .carry_out(carry_out));
    core_regfile u_regs (.clk_sys(clk_sys), .rst_n(rst_n), .ld(ld), .ld_val(ld_val),
        .new_val({carry_out, ptr_hi_out, ptr_lo_out, acc_out}), .we(we), .regs_q(regs_q));
    // ==========================================================
    // helpers
    // ==========================================================
    function automatic logic [31:0] lfsr_f(logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr_f
    // registers expected after one operation; zero divisor gives carry set, acc ff, rest 0
    function automatic logic [24:0] expect_f(op_t op, logic [24:0] r);
        logic [15:0] p;
        p = r[15:8] * r[7:0];
        if (op == OP_PRODUCT) return {r[24:16], p};
        if (r[15:8] == 8'h00) return {9'h100, r[15:8], 8'hff};
        p = {r[23:16], r[7:0]} / r[15:8];
        return {r[23:16] >= r[15:8], 8'({r[23:16], r[7:0]} % r[15:8]), r[15:8], p[7:0]};
    endfunction : expect_f
    task automatic fail(string m);
        mismatches++;
        $display("mismatch at %0t: %s", $time, m);
    endtask : fail
    task automatic results();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : results
    // one operation; twice raises a conflicting request for the first busy cycle only
    task automatic run(op_t op, logic [24:0] r, logic twice);
        int n;
        logic [24:0] e;
        e = expect_f(op, r);
        ld = 1'b1;
        ld_val = r;
        @(posedge clk_sys); #1;
        ld = 1'b0;
        op_start = 1'b1;
        op_sel = op;
        @(posedge clk_sys); #1;
        op_start = twice;
        op_sel = (op == OP_DIVIDE) ? OP_PRODUCT : OP_DIVIDE;
        n = 1;
        while (op_done !== 1'b1 && n < 20) begin
            @(posedge clk_sys); #1;
            op_start = 1'b0;
            n++;
        end
        checks += 3;
        if (n != ((op == OP_PRODUCT) ? PRODUCT_CYCLES : DIVIDE_CYCLES)) fail("latency");
        if (n >= 20) results();
        if (we !== ((op == OP_PRODUCT) ? 4'h3 : 4'hd)) fail("strobes");
        @(posedge clk_sys); #1;
        if (regs_q !== e) fail("registers");
        $display("test done op %s", op.name());
    endtask : run
    // ==========================================================
    // stimulus
    // ==========================================================
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    initial begin
        rst_n = 1'b0;
        op_start = 1'b0;
        op_sel = OP_NONE;
        ld = 1'b0;
        ld_val = 25'h0;
        seed = 32'hbb13;
        mismatches = 0;
        checks = 0;
        repeat (2) @(posedge clk_sys);
        #1;
        rst_n = 1'b1;
        op_start = 1'b1;
        // an empty operation must leave the unit quiet
        for (int i = 0; i < 8; i++) begin
            @(posedge clk_sys); #1;
            checks++;
            if ({busy, op_done, we} !== 6'h0) fail("idle outputs");
        end
        op_start = 1'b0;
        $display("test done idle");
        run(OP_PRODUCT, 25'h0_00_ff_ff, 1'b0);
        run(OP_PRODUCT, 25'h1_00_80_80, 1'b1);
        run(OP_DIVIDE, 25'h0_00_00_12, 1'b0);
        run(OP_DIVIDE, 25'h0_07_07_00, 1'b1);
        run(OP_DIVIDE, 25'h1_06_07_ff, 1'b0);
        for (int k = 0; k < 40; k++) begin
            seed = lfsr_f(seed);
            run(seed[0] ? OP_DIVIDE : OP_PRODUCT, seed[31:7], seed[1]);
        end
        results();
    end
endmodule : tb_byte_multiply_divide_unit
